// >>> rtl/aiacq_pkg.sv
// Shared constants and types for the analog input acquisition controller
package aiacq_pkg;
   typedef enum logic [1:0] {AIACQ_STD, AIACQ_SCOPE, AIACQ_FIFO} aiacq_mode_t;
   typedef enum logic [1:0] {AIACQ_TRIG_MANUAL, AIACQ_TRIG_RISE, AIACQ_TRIG_FALL}
      aiacq_trig_t;

   localparam int          NUM_CH        = 8;
   localparam int          SAMPLE_W      = 16;
   localparam int          CHAN_W        = 3;
   localparam int          IDX_W         = 16;
   localparam int          OBUF_DEPTH    = 16;
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          US_NS         = 1000;
   localparam int          TICK_CYC      = US_NS / CLK_PERIOD_NS;
   localparam logic [15:0] EOC_MIN_US    = 16'h00C8;
   localparam logic [16:0] SCOPE_DEPTH   = 17'h10000;
   localparam logic [12:0] RING_DEPTH    = 13'h1FFE;
   localparam logic [15:0] SAT_POS       = 16'h7FFF;
   localparam logic [15:0] SAT_NEG       = 16'h8000;
   localparam logic [7:0]  EVT_EOC       = 8'h01;
   localparam logic [15:0] DIG_SPACING   = 16'h0004;
   localparam logic [15:0] ANA_SPACING   = 16'h0100;
   localparam logic [2:0]  LAST_CH       = 3'h7;
endpackage

// >>> rtl/aiacq_fifo.sv
// Output buffer FIFO with registered read data
`timescale 1ns/100ps
module aiacq_fifo #(
   parameter int WIDTH = 35,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,       // module clock
   input  wire logic             rst_n,     // sync reset, active low
   input  wire logic             in_valid,  // write request
   output logic                  in_ready,  // space available
   input  wire logic [WIDTH-1:0] in_data,   // write word
   output logic                  out_valid, // read word present
   input  wire logic             out_ready, // reader takes word
   output logic      [WIDTH-1:0] out_data   // registered read word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
   logic [AW:0]      cnt_ff, nxt_cnt;
   logic             ov_ff, nxt_ov;
   logic [WIDTH-1:0] od_ff, nxt_od;
   logic             wr, rd;

   assign in_ready  = (cnt_ff != DEPTH[AW:0]);
   assign out_valid = ov_ff;
   assign out_data  = od_ff;

   always_comb begin
      wr       = in_valid && in_ready;
      // Refill output stage when empty or being taken
      rd       = (cnt_ff != '0) && (!ov_ff || out_ready);
      nxt_wptr = wr ? wptr_ff + 1'b1 : wptr_ff;
      nxt_rptr = rd ? rptr_ff + 1'b1 : rptr_ff;
      nxt_cnt  = cnt_ff + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
      nxt_ov   = rd ? 1'b1 : (out_ready ? 1'b0 : ov_ff);
      nxt_od   = rd ? mem[rptr_ff] : od_ff;
   end

   always_ff @(posedge clk) begin
      if (wr) begin
         mem[wptr_ff] <= in_data;
      end
      if (!rst_n) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         cnt_ff  <= '0;
         ov_ff   <= 1'b0;
         od_ff   <= '0;
      end else begin
         wptr_ff <= nxt_wptr;
         rptr_ff <= nxt_rptr;
         cnt_ff  <= nxt_cnt;
         ov_ff   <= nxt_ov;
         od_ff   <= nxt_od;
      end
   end
endmodule

// >>> rtl/aiacq_top.sv
// Acquisition controller: scan, oscilloscope capture, per-channel ring tracking
`timescale 1ns/100ps
module aiacq_top
   import aiacq_pkg::*;
(
   input  wire logic                clk,          // 20 MHz module clock
   input  wire logic                rst_n,        // sync reset, active low
   input  wire logic                acq_en,       // acquisition running
   input  wire logic [1:0]          cfg_mode,     // 0 std, 1 scope, 2 fifo
   input  wire logic [15:0]         cycle_time_us,// scan period in us
   input  wire logic                eoc_irq_en,   // end-of-cycle irq request
   input  wire logic [1:0]          trig_mode,    // 0 manual, 1 rise, 2 fall
   input  wire logic [15:0]         trig_level,   // edge threshold, signed
   input  wire logic                host_start,   // manual capture start pulse
   output logic                     adc_start,    // convert request pulse
   output logic [CHAN_W-1:0]        adc_chan,     // channel to convert
   input  wire logic                adc_done,     // conversion result valid
   input  wire logic [15:0]         adc_data,     // raw signed result
   input  wire logic                adc_over,     // above overdrive range
   input  wire logic                adc_under,    // below underdrive range
   input  wire logic                param_err,    // parameter error
   output logic                     out_valid,    // sample word to host
   input  wire logic                out_ready,    // host accepts word
   output logic [SAMPLE_W-1:0]      out_data,     // sample value
   output logic [CHAN_W-1:0]        out_chan,     // sample channel
   output logic [IDX_W-1:0]         out_idx,      // storage index
   output logic                     eoc_irq,      // end-of-cycle irq pulse
   output logic [31:0]              irq_data,     // four bytes irq data
   output logic                     scope_busy,   // capture in progress
   output logic                     scope_done,   // capture memory full
   input  wire logic                drain_req,    // host drained a packet
   input  wire logic [CHAN_W-1:0]   drain_chan,   // channel drained
   input  wire logic [12:0]         drain_cnt,    // words drained
   output logic [NUM_CH-1:0]        ovf_err,      // sticky overflow per channel
   input  wire logic [NUM_CH-1:0]   ovf_ack,      // clear overflow per channel
   input  wire logic [3:0]          slot_pos,     // slot number
   input  wire logic                is_digital,   // digital module class
   output logic [15:0]              base_addr     // derived start address
);
   typedef enum logic [1:0] {S_IDLE, S_CONV, S_PUSH} aiacq_state_t;

   aiacq_state_t       state_ff, nxt_state;
   aiacq_mode_t        mode_ff, nxt_mode;
   logic [CHAN_W-1:0]  ch_ff, nxt_ch;
   logic [15:0]        samp_ff, nxt_samp, prev0_ff, nxt_prev0;
   logic               start_ff, nxt_start, eoc_ff, nxt_eoc;
   logic [31:0]        irqd_ff, nxt_irqd;
   logic [15:0]        ncyc_ff, nxt_ncyc;
   logic [4:0]         div_ff, nxt_div;
   logic [15:0]        tmr_ff, nxt_tmr;
   logic               cap_ff, nxt_cap, done_ff, nxt_done, man_ff, nxt_man;
   logic [16:0]        scnt_ff, nxt_scnt;
   logic [15:0]        base_ff, nxt_base;
   logic               tick, due, store_en, push, trig_now, in_ready, cyc_ok;
   logic [IDX_W-1:0]   push_idx;
   logic [12:0]        wptr [NUM_CH];

   assign adc_start  = start_ff;
   assign adc_chan   = ch_ff;
   assign eoc_irq    = eoc_ff;
   assign irq_data   = irqd_ff;
   assign scope_busy = cap_ff;
   assign scope_done = done_ff;
   assign base_addr  = base_ff;
   assign cyc_ok     = (cycle_time_us >= EOC_MIN_US);

   always_comb begin
      nxt_div  = (div_ff == 5'(TICK_CYC - 1)) ? 5'h00 : div_ff + 5'h01;
      tick     = (div_ff == 5'(TICK_CYC - 1));
      due      = (tmr_ff >= cycle_time_us);
      nxt_tmr  = tmr_ff;
      if (!acq_en) begin
         nxt_tmr = cycle_time_us;
      end else if (state_ff == S_IDLE && due) begin
         nxt_tmr = 16'h0000;
      end else if (tick && !due) begin
         nxt_tmr = tmr_ff + 16'h0001;
      end
      nxt_base = is_digital ? 16'({slot_pos, 2'b00}) : 16'({slot_pos, 8'h00});
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_ch    = ch_ff;
      nxt_samp  = samp_ff;
      nxt_prev0 = prev0_ff;
      nxt_start = 1'b0;
      nxt_eoc   = 1'b0;
      nxt_irqd  = irqd_ff;
      nxt_ncyc  = ncyc_ff;
      nxt_cap   = cap_ff;
      nxt_done  = done_ff;
      nxt_scnt  = scnt_ff;
      nxt_man   = man_ff || host_start;
      nxt_mode  = mode_ff;
      push      = 1'b0;
      // manual or edge trigger on first channel
      case (trig_mode)
         AIACQ_TRIG_RISE: trig_now = ch_ff == '0 && $signed(prev0_ff) < $signed(trig_level)
                                     && $signed(samp_ff) >= $signed(trig_level);
         AIACQ_TRIG_FALL: trig_now = ch_ff == '0 && $signed(prev0_ff) >= $signed(trig_level)
                                     && $signed(samp_ff) < $signed(trig_level);
         default:         trig_now = man_ff;
      endcase
      trig_now = trig_now && mode_ff == AIACQ_SCOPE && !cap_ff && !done_ff;
      store_en = (mode_ff != AIACQ_SCOPE) || cap_ff || trig_now;
      case (state_ff)
         S_IDLE: begin
            if (acq_en && due) begin
               nxt_state = S_CONV;
               nxt_ch    = '0;
               nxt_start = 1'b1;
            end
         end
         S_CONV: begin
            if (adc_done) begin
               if (adc_over || param_err) begin
                  nxt_samp = SAT_POS;
               end else if (adc_under) begin
                  nxt_samp = SAT_NEG;
               end else begin
                  nxt_samp = adc_data;
               end
               nxt_state = S_PUSH;
            end
         end
         S_PUSH: begin
            // Full output buffer stalls the scan rather than drop words
            if (!store_en || in_ready) begin
               push = store_en;
               if (ch_ff == '0) begin
                  nxt_prev0 = samp_ff;
               end
               if (mode_ff == AIACQ_SCOPE && push) begin
                  nxt_scnt = scnt_ff + 17'h00001;
                  nxt_cap  = (scnt_ff + 17'h00001) != SCOPE_DEPTH;
                  nxt_done = (scnt_ff + 17'h00001) == SCOPE_DEPTH;
                  nxt_man  = 1'b0;
               end
               if (ch_ff == LAST_CH) begin
                  nxt_state = S_IDLE;
                  nxt_ncyc  = ncyc_ff + 16'h0001;
                  // fresh set stored; cycle gate; std only
                  if (mode_ff == AIACQ_STD && eoc_irq_en && cyc_ok) begin
                     nxt_eoc  = 1'b1;
                     nxt_irqd = {EVT_EOC, 8'h00, ncyc_ff};
                  end
               end else begin
                  nxt_ch    = ch_ff + 3'h1;
                  nxt_start = 1'b1;
                  nxt_state = S_CONV;
               end
            end
         end
         default: nxt_state = S_IDLE;
      endcase
      if (!acq_en) begin
         nxt_state = S_IDLE;
         nxt_mode  = (cfg_mode == 2'h1) ? AIACQ_SCOPE :
                     (cfg_mode == 2'h2) ? AIACQ_FIFO : AIACQ_STD;
         nxt_cap   = 1'b0;
         nxt_done  = 1'b0;
         nxt_scnt  = 17'h00000;
         nxt_man   = 1'b0;
         nxt_start = 1'b0;
         // Stale sample of a stopped run must not fake an edge
         nxt_prev0 = 16'h0000;
      end
      push_idx = (mode_ff == AIACQ_SCOPE) ? scnt_ff[15:0] : 16'(wptr[ch_ff]);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= S_IDLE;
         mode_ff  <= AIACQ_STD;
         ch_ff    <= '0;
         samp_ff  <= 16'h0000;
         prev0_ff <= 16'h0000;
         start_ff <= 1'b0;
         eoc_ff   <= 1'b0;
         irqd_ff  <= 32'h00000000;
         ncyc_ff  <= 16'h0000;
         div_ff   <= 5'h00;
         tmr_ff   <= 16'h0000;
         cap_ff   <= 1'b0;
         done_ff  <= 1'b0;
         man_ff   <= 1'b0;
         scnt_ff  <= 17'h00000;
         base_ff  <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         mode_ff  <= nxt_mode;
         ch_ff    <= nxt_ch;
         samp_ff  <= nxt_samp;
         prev0_ff <= nxt_prev0;
         start_ff <= nxt_start;
         eoc_ff   <= nxt_eoc;
         irqd_ff  <= nxt_irqd;
         ncyc_ff  <= nxt_ncyc;
         div_ff   <= nxt_div;
         tmr_ff   <= nxt_tmr;
         cap_ff   <= nxt_cap;
         done_ff  <= nxt_done;
         man_ff   <= nxt_man;
         scnt_ff  <= nxt_scnt;
         base_ff  <= nxt_base;
      end
   end

   for (genvar g = 0; g < NUM_CH; g++) begin : g_ring
      logic [12:0] ptr_ff, nxt_ptr, fill_ff, nxt_fill;
      logic        err_ff, nxt_err, st;
      assign wptr[g]    = ptr_ff;
      assign ovf_err[g] = err_ff;
      always_comb begin
         st       = push && mode_ff == AIACQ_FIFO && ch_ff == CHAN_W'(g);
         nxt_ptr  = ptr_ff;
         nxt_fill = fill_ff;
         if (drain_req && drain_chan == CHAN_W'(g)) begin
            nxt_fill = (drain_cnt > fill_ff) ? 13'h0000 : fill_ff - drain_cnt;
         end
         if (st) begin
            nxt_ptr = (ptr_ff == RING_DEPTH - 13'h0001) ? 13'h0000 : ptr_ff + 13'h0001;
            if (nxt_fill != RING_DEPTH) begin
               nxt_fill = nxt_fill + 13'h0001;
            end
         end
         nxt_err = err_ff && !ovf_ack[g];
         if (st && fill_ff == RING_DEPTH) begin
            nxt_err = 1'b1;
         end
         if (!acq_en) begin
            nxt_ptr  = 13'h0000;
            nxt_fill = 13'h0000;
         end
      end
      always_ff @(posedge clk) begin
         if (!rst_n) begin
            ptr_ff  <= 13'h0000;
            fill_ff <= 13'h0000;
            err_ff  <= 1'b0;
         end else begin
            ptr_ff  <= nxt_ptr;
            fill_ff <= nxt_fill;
            err_ff  <= nxt_err;
         end
      end
      a_fill_bound: assert property (@(posedge clk) disable iff (!rst_n)
         fill_ff <= RING_DEPTH) else $error("ring fill beyond depth");
      a_ovf_sticky: assert property (@(posedge clk) disable iff (!rst_n)
         err_ff && !ovf_ack[g] |=> err_ff) else $error("overflow flag lost");
      a_ovf_set: assert property (@(posedge clk) disable iff (!rst_n)
         st && fill_ff == RING_DEPTH |=> err_ff) else $error("overflow not flagged");
   end

   aiacq_fifo #(.WIDTH(SAMPLE_W + CHAN_W + IDX_W), .DEPTH(OBUF_DEPTH)) u_obuf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (push),
      .in_ready  (in_ready),
      .in_data   ({ch_ff, push_idx, samp_ff}),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  ({out_chan, out_idx, out_data})
   );

   a_eoc_gate: assert property (@(posedge clk) disable iff (!rst_n)
      eoc_irq |-> $past(cycle_time_us) >= EOC_MIN_US) else $error("eoc below 200us");
   a_no_irq_other: assert property (@(posedge clk) disable iff (!rst_n)
      mode_ff != AIACQ_STD |=> !eoc_irq) else $error("irq outside std mode");
   a_eoc_after_set: assert property (@(posedge clk) disable iff (!rst_n)
      eoc_irq |-> $past(state_ff) == S_PUSH && $past(ch_ff) == LAST_CH)
      else $error("eoc without fresh set");
   a_irq_data: assert property (@(posedge clk) disable iff (!rst_n)
      eoc_irq |-> irq_data[31:24] == EVT_EOC) else $error("bad irq data");
   a_scope_stop: assert property (@(posedge clk) disable iff (!rst_n)
      scope_done |-> !scope_busy && scnt_ff == SCOPE_DEPTH) else $error("capture overrun");
   a_sat_pos: assert property (@(posedge clk) disable iff (!rst_n)
      state_ff == S_CONV && adc_done && (adc_over || param_err) && acq_en
      |=> samp_ff == SAT_POS) else $error("no positive saturation");
   a_scan_chan: assert property (@(posedge clk) disable iff (!rst_n)
      adc_start && ch_ff != '0 |-> $past(ch_ff) == ch_ff - 3'h1)
      else $error("channel order broken");
   a_base_addr: assert property (@(posedge clk) disable iff (!rst_n)
      is_digital && $stable(slot_pos) && $stable(is_digital)
      |=> base_addr == 16'({$past(slot_pos), 2'b00})) else $error("bad digital address");
endmodule

// >>> verification/aiacq_adc_model.sv
// Behavioural converter answering the controller's conversion requests
`timescale 1ns/100ps
module aiacq_adc_model (
   input  wire logic       clk,       // module clock
   input  wire logic       adc_start, // convert request pulse
   input  wire logic [2:0] adc_chan,  // channel to convert
   input  wire logic       err_en,    // allow range and parameter flags
   input  wire logic       slow,      // stretch conversion time
   output logic            adc_done,  // result strobe
   output logic [15:0]     adc_data,  // signed result
   output logic            adc_over,  // above overdrive range
   output logic            adc_under, // below underdrive range
   output logic            param_err  // parameter error
);
   logic [21:0] conv_q[$]; // {over, under, perr, chan, data} in issue order
   logic [15:0] d;
   logic [2:0]  f;
   logic [2:0]  chan_ff;
   int          wait_cnt = -1;
   initial begin
      adc_done = 1'b0;
      adc_data = 16'h0000;
      {adc_over, adc_under, param_err} = 3'h0;
   end
   always @(posedge clk) begin
      adc_done <= 1'b0;
      // Released bus flips its data, so a stale value never passes
      if (adc_done) begin
         adc_data <= ~adc_data;
         {adc_over, adc_under, param_err} <= 3'h0;
      end
      if (adc_start) begin
         chan_ff  <= adc_chan;
         wait_cnt <= slow ? int'($urandom_range(5)) : 0;
      end else if (wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
      end else if (wait_cnt == 0) begin
         d = 16'($urandom);
         f = (err_en && $urandom_range(3) == 0) ? 3'($urandom) : 3'h0;
         adc_done <= 1'b1;
         adc_data <= d;
         {adc_over, adc_under, param_err} <= f;
         conv_q.push_back({f, chan_ff, d});
         wait_cnt <= -1;
      end
   end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the acquisition controller against a queue model
`timescale 1ns/100ps
module testbench;
   import aiacq_pkg::*;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               acq_en = 1'b0;
   logic               eoc_irq_en = 1'b0;
   logic               host_start = 1'b0;
   logic               out_ready = 1'b0;
   logic               drain_req = 1'b0;
   logic               is_digital = 1'b0;
   logic               err_en = 1'b0;
   logic               slow = 1'b0;
   logic [1:0]         cfg_mode = 2'h0;
   logic [1:0]         trig_mode = 2'h0;
   logic [15:0]        cycle_time_us = 16'h0000;
   logic [15:0]        trig_level = 16'h0000;
   logic [2:0]         drain_chan = 3'h0;
   logic [12:0]        drain_cnt = 13'h0000;
   logic [7:0]         ovf_ack = 8'h00;
   logic [3:0]         slot_pos = 4'h0;
   logic               adc_start, adc_done, adc_over, adc_under, param_err;
   logic               out_valid, eoc_irq, scope_busy, scope_done, trig_on, found;
   logic [2:0]         adc_chan, out_chan, exp_ch;
   logic [15:0]        adc_data, out_data, out_idx, base_addr, last_cnt;
   logic [31:0]        irq_data;
   logic [7:0]         ovf_err;
   logic [21:0]        c;
   logic signed [15:0] v, prev0, lvl;
   int                 mismatches = 0;
   int                 checked = 0;
   int                 md, words, ch7_words, eoc_cnt, idx_exp;
   int                 ptr[8];

   always #25 clk = ~clk;

   aiacq_top u_dut (
      .clk(clk), .rst_n(rst_n), .acq_en(acq_en), .cfg_mode(cfg_mode),
      .cycle_time_us(cycle_time_us), .eoc_irq_en(eoc_irq_en), .trig_mode(trig_mode),
      .trig_level(trig_level), .host_start(host_start), .adc_start(adc_start),
      .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data), .adc_over(adc_over),
      .adc_under(adc_under), .param_err(param_err), .out_valid(out_valid),
      .out_ready(out_ready), .out_data(out_data), .out_chan(out_chan), .out_idx(out_idx),
      .eoc_irq(eoc_irq), .irq_data(irq_data), .scope_busy(scope_busy),
      .scope_done(scope_done), .drain_req(drain_req), .drain_chan(drain_chan),
      .drain_cnt(drain_cnt), .ovf_err(ovf_err), .ovf_ack(ovf_ack), .slot_pos(slot_pos),
      .is_digital(is_digital), .base_addr(base_addr)
   );
   aiacq_adc_model u_adc (
      .clk(clk), .adc_start(adc_start), .adc_chan(adc_chan), .err_en(err_en), .slow(slow),
      .adc_done(adc_done), .adc_data(adc_data), .adc_over(adc_over),
      .adc_under(adc_under), .param_err(param_err)
   );

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wrap_up();
      if (mismatches == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   function automatic logic [15:0] sat(input logic [21:0] cv);
      if (cv[21] || cv[19])
         return SAT_POS;
      if (cv[20])
         return SAT_NEG;
      return cv[15:0];
   endfunction

   always @(posedge clk) begin
      if (rst_n && eoc_irq === 1'b1) begin
         chk("irq_event", {EVT_EOC, 8'h00}, irq_data[31:16]);
         if (eoc_cnt > 0) chk("irq_count", last_cnt + 16'h0001, irq_data[15:0]);
         last_cnt = irq_data[15:0];
         eoc_cnt++;
      end
      if (rst_n && out_valid === 1'b1 && out_ready) begin
         found = 1'b0;
         // Walk conversions in order; capture skips those before its start
         while (!found && u_adc.conv_q.size() > 0) begin
            c = u_adc.conv_q.pop_front();
            v = sat(c);
            if (c[18:16] == 3'h0) begin
               if (trig_mode == 2'h1 && prev0 < lvl && lvl <= v) trig_on = 1'b1;
               if (trig_mode == 2'h2 && prev0 >= lvl && lvl > v) trig_on = 1'b1;
               prev0 = v;
            end
            found = (md != 1) || trig_on;
         end
         if (!found) begin
            chk("stored_sample", 32'h1, 32'h0);
         end else begin
            chk("out_chan", {c[18:16], md == 1 ? c[18:16] : exp_ch}, {out_chan, out_chan});
            chk("out_data", $unsigned(v), out_data);
            chk("out_idx", md == 2 ? ptr[c[18:16]] : idx_exp, out_idx);
            if (md == 1) idx_exp++;
            if (md == 2) ptr[c[18:16]]++;
            if (out_chan === LAST_CH) ch7_words++;
            exp_ch++;
            words++;
         end
      end
   end

   task automatic run_phase(input logic [1:0] m, input logic [15:0] cyc, input logic en,
                            input logic [1:0] tm, input logic [15:0] lv, input int n,
                            input int stall);
      int k;
      int quiet;
      @(posedge clk);
      cfg_mode      <= m;
      cycle_time_us <= cyc;
      eoc_irq_en    <= en;
      trig_mode     <= tm;
      trig_level    <= lv;
      slot_pos      <= 4'($urandom);
      is_digital    <= ~is_digital;
      err_en        <= (m != 2'h1);
      slow          <= 1'($urandom);
      md = (m == 2'h3) ? 0 : int'(m);
      lvl = lv;
      trig_on = (tm == 2'h0);
      prev0 = 16'h0000;
      exp_ch = 3'h0;
      words = 0;
      ch7_words = 0;
      eoc_cnt = 0;
      idx_exp = 0;
      foreach (ptr[i]) ptr[i] = 0;
      repeat (3) @(posedge clk);
      chk("base_addr", is_digital ? {10'h000, slot_pos, 2'h0} : {4'h0, slot_pos, 8'h00}, base_addr);
      acq_en    <= 1'b1;
      out_ready <= (stall == 0);
      for (k = 0; k < n; k++) begin
         @(posedge clk);
         host_start <= (k == 0) && (m == 2'h1) && (tm == 2'h0);
         if (k == 1) cfg_mode <= ~m;
         if (k >= stall) out_ready <= 1'($urandom);
         drain_req  <= (m == 2'h2) && ($urandom_range(15) == 0);
         drain_chan <= 3'($urandom);
         drain_cnt  <= 13'($urandom_range(3));
         ovf_ack    <= 8'($urandom);
      end
      if (m == 2'h1 && words > 0) chk("scope_state", 32'h1, {scope_done, scope_busy});
      acq_en    <= 1'b0;
      out_ready <= 1'b1;
      drain_req <= 1'b0;
      quiet = 0;
      for (k = 0; k < 500 && quiet < 20; k++) begin
         @(posedge clk);
         quiet = (out_valid !== 1'b0) ? 0 : quiet + 1;
      end
      if (quiet < 20) begin
         chk("drain_time", 32'h1, 32'h0);
      end
      chk("words_seen", 32'h1, 32'(words > 0));
      chk("eoc_count", (md == 0 && en && cyc >= EOC_MIN_US) ? ch7_words : 0, eoc_cnt);
      chk("ovf_err", 32'h0, ovf_err);
      u_adc.conv_q.delete();
   endtask

   initial begin
      void'($urandom(27));
      repeat (5) @(posedge clk);
      chk("reset_quiet", 32'h0, {out_valid, adc_start, eoc_irq, scope_busy, scope_done, ovf_err});
      rst_n <= 1'b1;
      // Stalled host fills the output buffer first
      run_phase(2'h0, 16'h0000, 1'b1, 2'h0, 16'h0000, 3000, 400);
      run_phase(2'h0, 16'h00C7, 1'b1, 2'h0, 16'h0000, 9000, 0);
      run_phase(2'h3, 16'h00C8, 1'b1, 2'h0, 16'h0000, 9000, 0);
      run_phase(2'h1, 16'h0000, 1'b1, 2'h1, 16'h0000, 3000, 0);
      run_phase(2'h1, 16'h0000, 1'b1, 2'h2, 16'h0001, 3000, 0);
      run_phase(2'h1, 16'h0000, 1'b1, 2'h0, 16'h0000, 3000, 0);
      run_phase(2'h2, 16'h0000, 1'b1, 2'h0, 16'h0000, 4000, 100);
      wrap_up();
   end
endmodule
